// file: hdl/sfd_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module sfd_ctrl (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Serial port
    input  wire logic        ser_clk,
    input  wire logic        ser_data,
    input  wire logic        ser_cs_n,
    output logic             mux_out,
    // Loop status from the analog detectors
    input  wire logic        main_locked,
    input  wire logic        aux_locked,
    input  wire logic        steer_up,
    input  wire logic        steer_down,
    // Lock/steer pins
    input  wire logic        main_lock_steer_in,
    output logic             main_lock_steer_out,
    output logic             main_lock_steer_oe,
    input  wire logic        aux_lock_steer_in,
    output logic             aux_lock_steer_out,
    output logic             aux_lock_steer_oe,
    // Loop controls
    output logic [4:0]       main_phase_detector_gain,
    output logic [4:0]       aux_phase_detector_gain,
    output logic             internal_steer_en,
    output logic             main_ref_tick,
    output logic             aux_ref_tick,
    output logic [9:0]       main_div_value,
    output logic [9:0]       aux_div_value,
    // Power-down controls
    output logic             main_power_down,
    output logic             aux_power_down,
    output logic             osc_power_down
);

    // ------------------------------------------------------------------
    // Serial receiver
    // ------------------------------------------------------------------
    sfd_pkg::sfd_ser_e st_q;
    sfd_pkg::sfd_ser_e st_d;
    logic        sclk_prev_q;
    logic        cs_prev_q;
    logic [15:0] shift_q;
    logic [15:0] shift_d;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic        loop_bit_q;
    logic        loop_bit_d;
    logic        rise;
    logic        fall;
    logic        frame_end;

    assign rise      = ser_clk & ~sclk_prev_q;
    assign fall      = ~ser_clk & sclk_prev_q;
    assign frame_end = (st_q == sfd_pkg::SER_SHIFT) & ser_cs_n & ~cs_prev_q;

    always_comb begin
        st_d       = st_q;
        shift_d    = shift_q;
        cnt_d      = cnt_q;
        loop_bit_d = loop_bit_q;
        case (st_q)
            sfd_pkg::SER_IDLE: begin
                if (!ser_cs_n) begin
                    st_d  = sfd_pkg::SER_SHIFT;
                    cnt_d = 5'h00;
                end
            end
            sfd_pkg::SER_SHIFT: begin
                if (ser_cs_n) begin
                    st_d = sfd_pkg::SER_IDLE;
                end else if (rise) begin
                    // Older bits fall off the top: only the last 16 stay
                    shift_d = {shift_q[14:0], ser_data};
                    if (cnt_q != sfd_pkg::CNT_SAT) begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
                if (fall) begin
                    loop_bit_d = shift_q[0];
                end
            end
            default: st_d = sfd_pkg::SER_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q        <= sfd_pkg::SER_IDLE;
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
            shift_q     <= 16'h0000;
            cnt_q       <= 5'h00;
            loop_bit_q  <= 1'b0;
        end else begin
            st_q        <= st_d;
            sclk_prev_q <= ser_clk;
            cs_prev_q   <= ser_cs_n;
            shift_q     <= shift_d;
            cnt_q       <= cnt_d;
            loop_bit_q  <= loop_bit_d;
        end
    end

    // ------------------------------------------------------------------
    // Register file and main ratio staging
    // ------------------------------------------------------------------
    logic [15:0] regs_q [sfd_pkg::REG_COUNT];
    logic [15:0] regs_d [sfd_pkg::REG_COUNT];
    logic [3:0]  wr_adr;
    logic        wr_en;
    logic [15:0] wr_val;
    logic [10:0] act_div_q;
    logic [10:0] act_div_d;
    logic [17:0] act_dvd_q;
    logic [17:0] act_dvd_d;

    always_comb begin
        wr_adr = sfd_pkg::ADR_MOD_DATA;
        wr_val = {4'h0, shift_q[11:0]};
        wr_en  = 1'b0;
        if (frame_end && cnt_q != 5'h00) begin
            if (cnt_q < sfd_pkg::MOD_EDGE_LIMIT) begin
                wr_en = 1'b1;
            end else if (shift_q[15:12] < 4'(sfd_pkg::REG_COUNT)) begin
                wr_adr = shift_q[15:12];
                wr_en  = 1'b1;
            end
        end
        for (int i = 0; i < sfd_pkg::REG_COUNT; i++) begin
            regs_d[i] = regs_q[i];
        end
        if (wr_en) begin
            regs_d[wr_adr] = wr_val;
        end
        act_div_d = act_div_q;
        act_dvd_d = act_dvd_q;
        if (wr_en && wr_adr == sfd_pkg::ADR_MAIN_MSB) begin
            act_div_d = regs_q[sfd_pkg::ADR_MAIN_DIV][10:0];
            if (regs_q[sfd_pkg::ADR_MAIN_DIV][sfd_pkg::DIV_WIDE_BIT]) begin
                act_dvd_d = {wr_val[9:0],
                             regs_q[sfd_pkg::ADR_MAIN_LSB][7:0]};
            end else begin
                act_dvd_d = {wr_val[9:0], 8'h00};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < sfd_pkg::REG_COUNT; i++) begin
                regs_q[i] <= sfd_pkg::REG_RESET;
            end
            act_div_q <= 11'h000;
            act_dvd_q <= 18'h00000;
        end else begin
            regs_q    <= regs_d;
            act_div_q <= act_div_d;
            act_dvd_q <= act_dvd_d;
        end
    end

    // ------------------------------------------------------------------
    // Synthesizer units
    // ------------------------------------------------------------------
    logic [15:0] pwr;
    logic [15:0] pdc;
    logic [15:0] refd;
    logic [11:0] mod;
    logic [17:0] main_dvd;
    logic [17:0] aux_dvd;

    assign pwr      = regs_q[sfd_pkg::ADR_PWR_DN];
    assign pdc      = regs_q[sfd_pkg::ADR_PD_CTRL];
    assign refd     = regs_q[sfd_pkg::ADR_REF_DIV];
    assign mod      = regs_q[sfd_pkg::ADR_MOD_DATA][11:0];
    // Modulation samples ride on top of the staged main dividend
    assign main_dvd = pwr[sfd_pkg::MOD_EN_BIT]
                    ? act_dvd_q + {{6{mod[11]}}, mod}
                    : act_dvd_q;
    assign aux_dvd  = {regs_q[sfd_pkg::ADR_AUX_DVD][9:0], 8'h00};

    sfd_synth_unit u_main (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .run          (~pwr[sfd_pkg::PD_MAIN_BIT]),
        .ref_ratio_m1 (refd[4:0]),
        .int_mode     (act_div_q[sfd_pkg::DIV_INT_BIT]),
        .n_reg        (act_div_q[8:0]),
        .dividend     (main_dvd),
        .ref_tick     (main_ref_tick),
        .div_value    (main_div_value)
    );

    sfd_synth_unit u_aux (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .run          (~pwr[sfd_pkg::PD_AUX_BIT]),
        .ref_ratio_m1 (refd[9:5]),
        .int_mode     (regs_q[sfd_pkg::ADR_AUX_DIV][sfd_pkg::DIV_INT_BIT]),
        .n_reg        (regs_q[sfd_pkg::ADR_AUX_DIV][8:0]),
        .dividend     (aux_dvd),
        .ref_tick     (aux_ref_tick),
        .div_value    (aux_div_value)
    );

    assign main_phase_detector_gain = pdc[4:0];
    assign aux_phase_detector_gain  = pdc[9:5];
    assign main_power_down          = pwr[sfd_pkg::PD_MAIN_BIT];
    assign aux_power_down           = pwr[sfd_pkg::PD_AUX_BIT];
    assign osc_power_down           = pwr[sfd_pkg::PD_OSC_BIT];

    // ------------------------------------------------------------------
    // Lock detect and power steering pins
    // ------------------------------------------------------------------
    logic [7:0] ld_cnt_q;
    logic [7:0] ld_cnt_d;
    logic       m_out_q;
    logic       m_out_d;
    logic       m_oe_q;
    logic       m_oe_d;
    logic       a_oe_q;
    logic       a_oe_d;
    logic       steer_q;
    logic       steer_d;
    logic       pulse_lo;
    logic       mux_q;
    logic       mux_d;

    always_comb begin
        ld_cnt_d = (ld_cnt_q >= sfd_pkg::LD_PERIOD) ? 8'h00 : ld_cnt_q + 8'h01;
        pulse_lo = ld_cnt_q < sfd_pkg::LD_HALF;
        steer_d  = pdc[sfd_pkg::STEER_MODE_BIT];
        m_out_d  = 1'b0;
        m_oe_d   = 1'b0;
        if (pdc[sfd_pkg::STEER_MODE_BIT]) begin
            // Drive high to speed up, low to slow down, else release
            m_out_d = steer_up;
            m_oe_d  = steer_up ^ steer_down;
        end else begin
            m_oe_d = ~main_locked & pulse_lo;
        end
        a_oe_d = ~aux_locked & pulse_lo;
        mux_d  = 1'b0;
        case (regs_q[sfd_pkg::ADR_MUX_CTRL][2:0])
            sfd_pkg::MUX_SERIAL:    mux_d = loop_bit_q;
            sfd_pkg::MUX_MAIN_LOCK: mux_d = main_locked;
            sfd_pkg::MUX_MAIN_REF:  mux_d = main_ref_tick;
            sfd_pkg::MUX_AUX_REF:   mux_d = aux_ref_tick;
            sfd_pkg::MUX_MAIN_PIN:  mux_d = main_lock_steer_in;
            sfd_pkg::MUX_AUX_PIN:   mux_d = aux_lock_steer_in;
            default:                mux_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ld_cnt_q <= 8'h00;
            m_out_q  <= 1'b0;
            m_oe_q   <= 1'b0;
            a_oe_q   <= 1'b0;
            steer_q  <= 1'b0;
            mux_q    <= 1'b0;
        end else begin
            ld_cnt_q <= ld_cnt_d;
            m_out_q  <= m_out_d;
            m_oe_q   <= m_oe_d;
            a_oe_q   <= a_oe_d;
            steer_q  <= steer_d;
            mux_q    <= mux_d;
        end
    end

    assign main_lock_steer_out = m_out_q;
    assign main_lock_steer_oe  = m_oe_q;
    assign aux_lock_steer_out  = 1'b0;
    assign aux_lock_steer_oe   = a_oe_q;
    assign internal_steer_en   = ~steer_q;
    assign mux_out             = mux_q;

endmodule

`default_nettype wire

// file: include/sfd_pkg.sv
package sfd_pkg;

    // ------------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------------
    localparam int          FRAME_BITS     = 16;
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 12;
    localparam logic [4:0]  MOD_EDGE_LIMIT = 5'h0D;
    localparam logic [4:0]  CNT_SAT        = 5'h1F;
    localparam int          REG_COUNT      = 10;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [3:0]  ADR_MAIN_DIV   = 4'h0;
    localparam logic [3:0]  ADR_MAIN_MSB   = 4'h1;
    localparam logic [3:0]  ADR_MAIN_LSB   = 4'h2;
    localparam logic [3:0]  ADR_AUX_DIV    = 4'h3;
    localparam logic [3:0]  ADR_AUX_DVD    = 4'h4;
    localparam logic [3:0]  ADR_REF_DIV    = 4'h5;
    localparam logic [3:0]  ADR_PD_CTRL    = 4'h6;
    localparam logic [3:0]  ADR_PWR_DN     = 4'h7;
    localparam logic [3:0]  ADR_MUX_CTRL   = 4'h8;
    localparam logic [3:0]  ADR_MOD_DATA   = 4'h9;
    localparam logic [15:0] REG_RESET      = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          DIV_INT_BIT    = 9;
    localparam int          DIV_WIDE_BIT   = 10;
    localparam int          REF_AUX_LSB    = 5;
    localparam int          GAIN_AUX_LSB   = 5;
    localparam int          STEER_MODE_BIT = 10;
    localparam int          PD_MAIN_BIT    = 0;
    localparam int          PD_AUX_BIT     = 1;
    localparam int          PD_OSC_BIT     = 2;
    localparam int          MOD_EN_BIT     = 3;

    // ------------------------------------------------------------------
    // Mux output selections
    // ------------------------------------------------------------------
    localparam logic [2:0]  MUX_ZERO       = 3'h0;
    localparam logic [2:0]  MUX_SERIAL     = 3'h1;
    localparam logic [2:0]  MUX_MAIN_LOCK  = 3'h2;
    localparam logic [2:0]  MUX_MAIN_REF   = 3'h3;
    localparam logic [2:0]  MUX_AUX_REF    = 3'h4;
    localparam logic [2:0]  MUX_MAIN_PIN   = 3'h5;
    localparam logic [2:0]  MUX_AUX_PIN    = 3'h6;

    // ------------------------------------------------------------------
    // Divider figures and timing
    // ------------------------------------------------------------------
    localparam logic [9:0]  N_OFFSET       = 10'h020;
    localparam logic [17:0] DVD_ONE        = 18'h3FFFF;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          LD_PULSE_NS    = 1000;
    localparam int          LD_PULSE_CYC   = LD_PULSE_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  LD_PERIOD      = 8'(LD_PULSE_CYC - 1);
    localparam logic [7:0]  LD_HALF        = 8'(LD_PULSE_CYC / 2);

    typedef enum logic [1:0] {
        SER_IDLE  = 2'b01,
        SER_SHIFT = 2'b10
    } sfd_ser_e;

endpackage

// file: hdl/sfd_synth_unit.sv
`timescale 1ns/1ps
`default_nettype none

module sfd_synth_unit (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Configuration
    input  wire logic        run,
    input  wire logic [4:0]  ref_ratio_m1,
    input  wire logic        int_mode,
    input  wire logic [8:0]  n_reg,
    input  wire logic [17:0] dividend,
    // Results
    output logic             ref_tick,
    output logic [9:0]       div_value
);

    // ------------------------------------------------------------------
    // Reference divider, ratio 1 to 32
    // ------------------------------------------------------------------
    logic [4:0] ref_cnt_q;
    logic [4:0] ref_cnt_d;
    logic       tick_q;
    logic       tick_d;

    always_comb begin
        ref_cnt_d = ref_cnt_q;
        tick_d    = 1'b0;
        if (run) begin
            if (ref_cnt_q >= ref_ratio_m1) begin
                ref_cnt_d = 5'h00;
                tick_d    = 1'b1;
            end else begin
                ref_cnt_d = ref_cnt_q + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fractional unit: first-order modulator on a signed accumulator
    // ------------------------------------------------------------------
    logic signed [18:0] acc_q;
    logic signed [18:0] acc_d;
    logic signed [18:0] sum;
    logic [9:0]         div_d;
    logic [9:0]         div_q;
    logic [9:0]         base;

    always_comb begin
        base  = {1'b0, n_reg} + sfd_pkg::N_OFFSET;
        acc_d = acc_q;
        div_d = div_q;
        sum   = acc_q + {dividend[17], dividend};
        if (tick_q) begin
            if (int_mode) begin
                acc_d = '0;
                div_d = base;
            end else if (sum > $signed({1'b0, sfd_pkg::DVD_ONE >> 1})) begin
                // Carry up: output one above the integer part
                acc_d = sum - 19'sh40000;
                div_d = base + 10'h001;
            end else if (sum < -$signed({1'b0, sfd_pkg::DVD_ONE >> 1})) begin
                acc_d = sum + 19'sh40000;
                div_d = base - 10'h001;
            end else begin
                acc_d = sum;
                div_d = base;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_q <= 5'h00;
            tick_q    <= 1'b0;
            acc_q     <= 19'sh00000;
            div_q     <= sfd_pkg::N_OFFSET;
        end else begin
            ref_cnt_q <= ref_cnt_d;
            tick_q    <= tick_d;
            acc_q     <= acc_d;
            div_q     <= div_d;
        end
    end

    assign ref_tick  = tick_q;
    assign div_value = div_q;

endmodule

`default_nettype wire

// file: test/sfd_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none

module sfd_ctrl_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // Serial select and loop status
    input wire logic       ser_cs_n,
    input wire logic       main_locked,
    input wire logic       steer_up,
    input wire logic       steer_down,
    // Watched outputs
    input wire logic       main_lock_steer_out,
    input wire logic       main_lock_steer_oe,
    input wire logic [4:0] main_phase_detector_gain,
    input wire logic       internal_steer_en,
    input wire logic       main_ref_tick,
    input wire logic [9:0] main_div_value,
    input wire logic       main_power_down,
    input wire logic       osc_power_down
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // --------
    // Pulse length in lock mode
    // --------
    logic [7:0] run_d;
    logic [7:0] run_q;

    always_comb begin
        run_d = 8'h00;
        if (main_lock_steer_oe && internal_steer_en) begin
            run_d = run_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 8'h00;
        end else begin
            run_q <= run_d;
        end
    end

    AST_LOCK_OUT_LOW: assert property (
        internal_steer_en [*4] |-> !main_lock_steer_out)
        else $error("lock pin driven high in lock mode");
    AST_LOCK_RELEASE: assert property (
        (internal_steer_en && main_locked) [*4] |-> !main_lock_steer_oe)
        else $error("lock pin not released while locked");
    AST_STEER_UP: assert property (
        (!internal_steer_en && steer_up && !steer_down) [*4]
        |-> main_lock_steer_oe && main_lock_steer_out)
        else $error("steer pin not pushing up");
    AST_STEER_IDLE: assert property (
        (!internal_steer_en && (steer_up == steer_down)) [*4]
        |-> !main_lock_steer_oe)
        else $error("steer pin driven without a request");
    AST_PULSE_MAX: assert property (run_q <= 8'h32)
        else $error("lock pulse longer than half a period");
    AST_PULSE_CAUSE: assert property (
        $rose(main_lock_steer_oe) && internal_steer_en
        && $past(internal_steer_en, 3) |-> !$past(main_locked))
        else $error("lock pulse while locked");
    AST_PWR_FRAME: assert property (
        $changed({main_power_down, osc_power_down}) |-> $past(ser_cs_n)
        && !($past(ser_cs_n, 2) && $past(ser_cs_n, 3)))
        else $error("power-down changed outside a frame end");
    AST_GAIN_FRAME: assert property (
        $changed(main_phase_detector_gain) |-> $past(ser_cs_n)
        && !($past(ser_cs_n, 2) && $past(ser_cs_n, 3)))
        else $error("gain changed outside a frame end");
    AST_DIV_TICK: assert property (
        $changed(main_div_value)
        |-> $past(main_ref_tick) || $past(main_ref_tick, 2))
        else $error("divide value changed without a ref tick");
endmodule

bind sfd_ctrl sfd_ctrl_chk i_sfd_ctrl_chk (.*);

`default_nettype wire

// file: test/sfd_ser_master.sv
`timescale 1ns/1ps
`default_nettype none

module sfd_ser_master (
    // Clock
    input  wire logic clk_sys,
    // Three-wire bus
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_cs_n
);
    // Each phase spans three clocks, above the two-clock sampling floor
    localparam int HALF = 3;

    initial begin
        ser_clk  = 1'b0;
        ser_data = 1'b0;
        ser_cs_n = 1'b1;
    end

    task automatic open_frame();
        @(posedge clk_sys);
        ser_cs_n <= 1'b0;
        repeat (HALF) @(posedge clk_sys);
    endtask

    task automatic bit_out(input logic b);
        ser_data <= b;
        repeat (HALF) @(posedge clk_sys);
        ser_clk <= 1'b1;
        repeat (HALF) @(posedge clk_sys);
        ser_clk <= 1'b0;
    endtask

    task automatic close_frame();
        repeat (HALF) @(posedge clk_sys);
        ser_cs_n <= 1'b1;
        // Released line must not keep showing the last bit
        ser_data <= ~ser_data;
        repeat (HALF) @(posedge clk_sys);
    endtask
endmodule

`default_nettype wire

// file: test/sfd_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sfd_ctrl_bench;
    logic       clk_sys, rst_n, ser_clk, ser_data, ser_cs_n, mux_out;
    logic       main_locked, aux_locked, steer_up, steer_down;
    logic       main_lock_steer_in, main_lock_steer_out, main_lock_steer_oe;
    logic       aux_lock_steer_in, aux_lock_steer_out, aux_lock_steer_oe;
    logic [4:0] main_phase_detector_gain, aux_phase_detector_gain;
    logic       internal_steer_en, main_ref_tick, aux_ref_tick;
    logic [9:0] main_div_value, aux_div_value, v;
    logic       main_power_down, aux_power_down, osc_power_down;
    logic [19:0] lw;
    int         fails, checks_done, p, lo, hi, n;

    sfd_ctrl i_sfd_ctrl (.*);
    sfd_ser_master i_sfd_ser_master (.*);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // --------
    // Tasks
    // --------
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic smp(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [3:0] adr, input logic [11:0] dat);
        logic [15:0] w;
        w = {adr, dat};
        i_sfd_ser_master.open_frame();
        for (int i = 15; i >= 0; i--) i_sfd_ser_master.bit_out(w[i]);
        i_sfd_ser_master.close_frame();
    endtask

    task automatic wait_tick(input logic aux);
        int k;
        k = 0;
        do begin
            smp(1);
            k++;
        end while ((aux ? aux_ref_tick : main_ref_tick) !== 1'b1 && k < 400);
        if (k >= 400) begin
            fails++;
            $display("Error ref tick expected 1 seen 0");
        end
    endtask

    task automatic div_at(input logic aux, output logic [9:0] d);
        wait_tick(aux);
        smp(2);
        d = aux ? aux_div_value : main_div_value;
    endtask

    task automatic per(input logic aux, output int q);
        wait_tick(aux);
        q = 0;
        do begin
            smp(1);
            q++;
        end while ((aux ? aux_ref_tick : main_ref_tick) !== 1'b1 && q < 100);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Covers about 50k cycles of tests
    initial begin
        #500_000;
        fails++;
        end_of_test();
    end

    // --------
    // Tests
    // --------
    initial begin
        rst_n = 1'b0;
        main_locked = 1'b0;
        aux_locked = 1'b1;
        steer_up = 1'b0;
        steer_down = 1'b0;
        main_lock_steer_in = 1'b1;
        aux_lock_steer_in = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        smp(2);
        chk("main gain", 16'h0000, 16'(main_phase_detector_gain));
        chk("main div", 16'h0020, 16'(main_div_value));
        chk("steer en", 16'h0001, 16'(internal_steer_en));
        $display("reset test done");
        // Four leading junk bits must be dropped
        lw = {4'h9, sfd_pkg::ADR_PD_CTRL, 12'h156};
        i_sfd_ser_master.open_frame();
        for (int i = 19; i >= 0; i--) i_sfd_ser_master.bit_out(lw[i]);
        i_sfd_ser_master.close_frame();
        smp(2);
        chk("main gain", 16'h0016, 16'(main_phase_detector_gain));
        chk("aux gain", 16'h000A, 16'(aux_phase_detector_gain));
        // Read as an address frame these 12 bits would set gain 15
        i_sfd_ser_master.open_frame();
        for (int i = 15; i >= 4; i--) i_sfd_ser_master.bit_out(lw[i]);
        i_sfd_ser_master.close_frame();
        smp(2);
        chk("short gain", 16'h0016, 16'(main_phase_detector_gain));
        for (int i = 0; i < 3; i++) begin
            wr(sfd_pkg::ADR_PWR_DN, 12'h001 << i);
            smp(2);
            chk("power", 16'h0001 << i,
                16'({osc_power_down, aux_power_down, main_power_down}));
        end
        wr(sfd_pkg::ADR_PWR_DN, 12'h000);
        wr(sfd_pkg::ADR_MUX_CTRL, 12'h001);
        smp(2);
        chk("mux loop", 16'h0001, 16'(mux_out));
        wr(4'hA, 12'h000);
        smp(2);
        chk("mux loop", 16'h0000, 16'(mux_out));
        wr(sfd_pkg::ADR_MUX_CTRL, 12'h005);
        @(posedge clk_sys);
        main_lock_steer_in <= 1'b0;
        smp(3);
        chk("mux pin", 16'h0000, 16'(mux_out));
        $display("register test done");
        wr(sfd_pkg::ADR_MAIN_DIV, 12'h3FF);
        div_at(1'b0, v);
        chk("main div held", 16'h0020, 16'(v));
        wr(sfd_pkg::ADR_MAIN_MSB, 12'h000);
        div_at(1'b0, v);
        chk("main div int", 16'h021F, 16'(v));
        wr(sfd_pkg::ADR_AUX_DIV, 12'h200);
        div_at(1'b1, v);
        chk("aux div int", 16'h0020, 16'(v));
        wr(sfd_pkg::ADR_AUX_DIV, 12'h006);
        wr(sfd_pkg::ADR_AUX_DVD, 12'h000);
        div_at(1'b1, v);
        chk("aux div frac", 16'h0026, 16'(v));
        wr(sfd_pkg::ADR_AUX_DIV, 12'h1F9);
        wr(sfd_pkg::ADR_AUX_DVD, 12'h1FF);
        lo = 0;
        hi = 0;
        repeat (32) begin
            div_at(1'b1, v);
            lo += int'(v === 10'h219);
            hi += int'(v === 10'h21A);
        end
        chk("aux frac mix", 16'h0001,
            16'(lo > 0 && hi > 0 && lo + hi == 32));
        wr(sfd_pkg::ADR_REF_DIV, 12'h3E4);
        per(1'b0, p);
        chk("main ref period", 16'h0005, 16'(p));
        per(1'b1, p);
        chk("aux ref period", 16'h0020, 16'(p));
        $display("divider test done");
        @(posedge clk_sys);
        aux_locked <= 1'b0;
        smp(2);
        n = 0;
        lo = 0;
        repeat (200) begin
            smp(1);
            n += int'(main_lock_steer_oe === 1'b1);
            lo += int'(aux_lock_steer_oe === 1'b1);
        end
        chk("unlock pulse cycles", 16'h0064, 16'(n));
        chk("aux pulse cycles", 16'h0064, 16'(lo));
        chk("aux pin level", 16'h0000, 16'(aux_lock_steer_out));
        @(posedge clk_sys);
        main_locked <= 1'b1;
        smp(4);
        chk("locked oe", 16'h0000, 16'(main_lock_steer_oe));
        wr(sfd_pkg::ADR_PD_CTRL, 12'h55F);
        smp(2);
        chk("steer en", 16'h0000, 16'(internal_steer_en));
        steer_up <= 1'b1;
        smp(4);
        chk("steer up", 16'h0003,
            16'({main_lock_steer_oe, main_lock_steer_out}));
        @(posedge clk_sys);
        steer_down <= 1'b1;
        smp(4);
        chk("steer both", 16'h0000, 16'(main_lock_steer_oe));
        @(posedge clk_sys);
        steer_up <= 1'b0;
        smp(4);
        chk("steer down", 16'h0002,
            16'({main_lock_steer_oe, main_lock_steer_out}));
        $display("lock pin test done");
        end_of_test();
    end
endmodule

`default_nettype wire
